// File: rtl/pmc_pkg.sv
// Types shared by the config bank
package pmc_pkg;
   typedef logic [15:0] pmc_word_t;
   typedef logic [6:0] pmc_addr_t;
   typedef enum logic {PMC_VAR_FIXED, PMC_VAR_STRAP} pmc_variant_t;
endpackage : pmc_pkg

// File: rtl/pmc_regs.sv
// Config and status register bank for the MAC interface and fast ethernet path
`include "pmc_regs_map.svh"

module pmc_regs #(
   parameter pmc_pkg::pmc_variant_t VARIANT = pmc_pkg::PMC_VAR_FIXED
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [6:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic mac_if_enable_strap,
   input wire logic serial_page_received_in,
   input wire logic serial_negotiation_done_in,
   output logic mac_if_enable,
   output logic [1:0] rx_fifo_midpoint_level,
   output logic [1:0] tx_fifo_midpoint_level,
   output logic tx_clock_shift,
   output logic rx_clock_shift,
   output logic async_fifo_skip,
   output logic async_fifo_skip_rx_clock_delay,
   output logic low_latency_slow_modes,
   output logic descrambler_timeout_off,
   output logic [3:0] descrambler_recovery_ms,
   output logic force_fast_link_good,
   output logic enhanced_three_level_detect,
   output logic enhanced_gap_detect,
   output logic scrambler_off,
   output logic odd_nibble_detect,
   output logic early_rx_valid
);
   import pmc_pkg::*;

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic [7:0] ctl_ff;
   logic [15:0] ctl2_ff;
   logic [15:0] fec_ff;
   logic [15:0] rdata_ff;
   logic strap_done_ff;
   logic [1:0] sns_sync;
   logic [15:0] nxt_rdata;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire hit_ctl = (reg_addr == `PMC_OFS_CTL);
   wire hit_ctl2 = (reg_addr == `PMC_OFS_CTL2);
   wire hit_sns = (reg_addr == `PMC_OFS_SNS);
   wire hit_fec = (reg_addr == `PMC_OFS_FEC);
   wire wr_ctl = reg_wr && hit_ctl;
   wire wr_ctl2 = reg_wr && hit_ctl2;
   wire wr_fec = reg_wr && hit_fec;

   // Status word; upper bits fixed at zero
   wire [15:0] sns_word = {14'h0000, sns_sync};

   // Masked write values keep reserved bits at their fixed levels
   wire [15:0] ctl_wmask = `PMC_WMSK_CTL;
   wire [7:0] nxt_ctl = reg_wdata[7:0] & ctl_wmask[7:0];
   wire [15:0] nxt_ctl2 = reg_wdata & `PMC_WMSK_CTL2;
   wire [15:0] nxt_fec = reg_wdata & `PMC_WMSK_FEC;

   // Read mux; unmapped addresses read as zero
   assign nxt_rdata = hit_ctl ? {8'h00, ctl_ff} :
                      hit_ctl2 ? ctl2_ff :
                      hit_sns ? sns_word :
                      hit_fec ? fec_ff : 16'h0000;

   // ----------------------------------------
   // Status inputs come from another domain
   // ----------------------------------------
   pmc_sync #(
      .WIDTH(2)
   ) u_sync (
      .mclk(mclk),
      .rst_b(rst_b),
      .async_in({serial_page_received_in, serial_negotiation_done_in}),
      .sync_out(sns_sync)
   );

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   // Enable bit resets to one; the strapped variant loads the pin
   // on the first edge after release, since async reset takes constants only
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ctl_ff <= `PMC_RST_CTL_LOW | 8'h80;
         strap_done_ff <= 1'b0;
      end else begin
         strap_done_ff <= 1'b1;
         if (wr_ctl) begin
            ctl_ff <= nxt_ctl;
         end else if (!strap_done_ff && VARIANT == PMC_VAR_STRAP) begin
            ctl_ff[`PMC_CTL_EN_BIT] <= mac_if_enable_strap;
         end
      end
   end

   // Second control and fast ethernet registers
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ctl2_ff <= `PMC_RST_CTL2;
         fec_ff <= `PMC_RST_FEC;
      end else begin
         if (wr_ctl2) begin
            ctl2_ff <= nxt_ctl2;
         end
         if (wr_fec) begin
            fec_ff <= nxt_fec;
         end
      end
   end

   // Read data valid the cycle after the strobe only
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_ff <= 16'h0000;
      end else begin
         rdata_ff <= reg_rd ? nxt_rdata : 16'h0000;
      end
   end

   assign reg_rdata = rdata_ff;

   // ----------------------------------------
   // Control outputs to the datapath
   // ----------------------------------------
   assign mac_if_enable = ctl_ff[`PMC_CTL_EN_BIT];
   assign rx_fifo_midpoint_level = ctl_ff[`PMC_CTL_RXL_HI:`PMC_CTL_RXL_LO];
   assign tx_fifo_midpoint_level = ctl_ff[`PMC_CTL_TXL_HI:`PMC_CTL_TXL_LO];
   assign tx_clock_shift = ctl_ff[`PMC_CTL_TXD_BIT];
   assign rx_clock_shift = ctl_ff[`PMC_CTL_RXD_BIT];
   assign async_fifo_skip = ctl2_ff[`PMC_CTL2_SKIP_BIT];
   assign async_fifo_skip_rx_clock_delay = ctl2_ff[`PMC_CTL2_SKD_BIT];
   assign low_latency_slow_modes = ctl2_ff[`PMC_CTL2_LL_BIT];
   assign descrambler_timeout_off = fec_ff[`PMC_FEC_TOD_BIT];
   assign descrambler_recovery_ms = fec_ff[`PMC_FEC_REC_HI:`PMC_FEC_REC_LO];
   assign force_fast_link_good = fec_ff[`PMC_FEC_F100_BIT];
   assign enhanced_three_level_detect = fec_ff[`PMC_FEC_MLT_BIT];
   assign enhanced_gap_detect = fec_ff[`PMC_FEC_IPG_BIT];
   assign scrambler_off = fec_ff[`PMC_FEC_SCR_BIT];
   assign odd_nibble_detect = fec_ff[`PMC_FEC_ODD_BIT];
   assign early_rx_valid = fec_ff[`PMC_FEC_ERX_BIT];
endmodule : pmc_regs

// File: rtl/pmc_regs_map.svh
// Register offsets, field positions, reset values and the rule overview for the config bank
// Overview of operation
// - Control high byte reads zero, ignores writes
// - Control bit 7 enables MAC interface
// - Bits 6:5 receive FIFO midpoint, reset 10
// - Bits 4:3 transmit FIFO midpoint, reset 10
// - Bit 1 shifts transmit clock versus data
// - Bit 0 shifts receive clock versus data
// - Control two bit 4 skips async FIFO
// - Control two bit 3 delays slow receive clock
// - Control two bit 2 enables low latency
// - Status bit 1 shows page received
// - Status bit 0 shows negotiation done
// - Config bit 11 governs descrambler timeout stop
// - Bits 10:7 recovery timeout ms, reset 1111
// - Config bit 6 forces fast link good
// - Config bit 5 enhanced three-level detect, reset 1
// - Config bit 4 enhanced gap detect
// - Config bit 2 switches scrambler off
// - Config bit 1 detects odd nibble count
// - Config bit 0 enables early receive valid
`ifndef PMC_REGS_MAP_SVH
`define PMC_REGS_MAP_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define PMC_OFS_CTL 7'h32
`define PMC_OFS_CTL2 7'h33
`define PMC_OFS_SNS 7'h37
`define PMC_OFS_FEC 7'h43

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PMC_CTL_EN_BIT 7
`define PMC_CTL_RXL_HI 6
`define PMC_CTL_RXL_LO 5
`define PMC_CTL_TXL_HI 4
`define PMC_CTL_TXL_LO 3
`define PMC_CTL_TXD_BIT 1
`define PMC_CTL_RXD_BIT 0
`define PMC_CTL2_SKIP_BIT 4
`define PMC_CTL2_SKD_BIT 3
`define PMC_CTL2_LL_BIT 2
`define PMC_SNS_PAGE_BIT 1
`define PMC_SNS_DONE_BIT 0
`define PMC_FEC_TOD_BIT 11
`define PMC_FEC_REC_HI 10
`define PMC_FEC_REC_LO 7
`define PMC_FEC_F100_BIT 6
`define PMC_FEC_MLT_BIT 5
`define PMC_FEC_IPG_BIT 4
`define PMC_FEC_SCR_BIT 2
`define PMC_FEC_ODD_BIT 1
`define PMC_FEC_ERX_BIT 0

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define PMC_RST_CTL_LOW 8'h50
`define PMC_RST_CTL2 16'h0000
`define PMC_RST_FEC 16'h07A0
`define PMC_WMSK_CTL 16'h00FB
`define PMC_WMSK_CTL2 16'h001C
`define PMC_WMSK_FEC 16'h0FF7

`endif

// File: rtl/pmc_sync.sv
// Three-stage input synchroniser with agreement filter
module pmc_sync #(
   parameter int WIDTH = 2
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] s2_ff;
   logic [WIDTH-1:0] s3_ff;
   logic [WIDTH-1:0] out_ff;
   logic [WIDTH-1:0] nxt_out;

   // A zero-width chain has nothing to carry
   if (WIDTH < 1) begin : g_width_check
      $error("pmc_sync WIDTH must be at least one");
   end

   // A change counts only once stages two and three agree
   genvar gi;
   for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      assign nxt_out[gi] = (s2_ff[gi] == s3_ff[gi]) ? s2_ff[gi] : out_ff[gi];
   end

   // Chain; first stage feeds only the second
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         meta_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         out_ff <= '0;
      end else begin
         meta_ff <= async_in;
         s2_ff <= meta_ff;
         s3_ff <= s2_ff;
         out_ff <= nxt_out;
      end
   end

   assign sync_out = out_ff;
endmodule : pmc_sync

// File: tb/pmc_regs_properties.sv
// Checker for the config bank register port and its control outputs
module pmc_regs_properties (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [6:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic mac_if_enable,
   input wire logic [3:0] descrambler_recovery_ms,
   input wire logic scrambler_off
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // Strobe decodes for the control, status and config registers
   wire logic rd_ctl = reg_rd && reg_addr == 7'h32;
   wire logic wr_ctl = reg_wr && reg_addr == 7'h32;
   wire logic rd_sns = reg_rd && reg_addr == 7'h37;
   wire logic rd_fec = reg_rd && reg_addr == 7'h43;
   wire logic wr_fec = reg_wr && reg_addr == 7'h43;
   // Read data must not linger, or a stale word could be taken as a fresh one
   property p_idle_zero; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
   property p_ctl_rsv; rd_ctl |=> reg_rdata[15:8] == 8'h00 && !reg_rdata[2]; endproperty
   property p_en_wr; wr_ctl |=> mac_if_enable == $past(reg_wdata[7]); endproperty
   property p_en_rd; rd_ctl ##1 1'b1 |-> reg_rdata[7] == mac_if_enable; endproperty
   property p_rec_wr; wr_fec |=> descrambler_recovery_ms == $past(reg_wdata[10:7]); endproperty
   property p_rec_hold; !wr_fec |=> $stable(descrambler_recovery_ms); endproperty
   property p_scr_wr; wr_fec |=> scrambler_off == $past(reg_wdata[2]); endproperty
   property p_fec_rd;
      rd_fec |=> reg_rdata[15:12] == 4'h0 && reg_rdata[10:7] == descrambler_recovery_ms;
   endproperty
   property p_sns_rd; rd_sns |=> reg_rdata[15:2] == 14'h0000; endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("read data not idle");
   a_ctl_rsv: assert property (p_ctl_rsv) else $error("control reserved bits set");
   a_en_wr: assert property (p_en_wr) else $error("enable not written");
   a_en_rd: assert property (p_en_rd) else $error("enable readback wrong");
   a_rec_wr: assert property (p_rec_wr) else $error("recovery field not written");
   a_rec_hold: assert property (p_rec_hold) else $error("recovery field moved");
   a_scr_wr: assert property (p_scr_wr) else $error("scrambler bit not written");
   a_fec_rd: assert property (p_fec_rd) else $error("config readback wrong");
   a_sns_rd: assert property (p_sns_rd) else $error("status reserved bits set");
   // Main traffic kinds
   c_wr_ctl: cover property (wr_ctl);
   c_rd_fec: cover property (rd_fec ##1 reg_rdata != 16'h0000);
   c_sns: cover property (rd_sns ##1 reg_rdata[1:0] == 2'b11);
endmodule : pmc_regs_properties

// File: tb/pmc_regs_tb_top.sv
// Self-checking bench for the config bank
`include "pmc_regs_map.svh"
module pmc_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import pmc_pkg::*;
   logic mclk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, mac_if_enable_strap = 1'b0;
   logic serial_page_received_in = 1'b0, serial_negotiation_done_in = 1'b0;
   pmc_addr_t reg_addr = 7'h00;
   pmc_word_t reg_wdata = 16'h0000;
   pmc_word_t reg_rdata;
   logic mac_if_enable, tx_clock_shift, rx_clock_shift, async_fifo_skip, scrambler_off;
   logic async_fifo_skip_rx_clock_delay, low_latency_slow_modes, descrambler_timeout_off;
   logic force_fast_link_good, enhanced_three_level_detect, enhanced_gap_detect;
   logic odd_nibble_detect, early_rx_valid;
   logic strap_en;
   logic [1:0] rx_fifo_midpoint_level, tx_fifo_midpoint_level;
   logic [3:0] descrambler_recovery_ms;
   int errors = 0, checks_done = 0;
   pmc_word_t o_w [4];
   pmc_addr_t adr [4] = '{7'h32, 7'h33, 7'h37, 7'h43};
   pmc_word_t msk [4] = '{`PMC_WMSK_CTL, `PMC_WMSK_CTL2, 16'h0000, `PMC_WMSK_FEC};
   pmc_word_t rst_v [4] = '{16'h00D0, 16'h0000, 16'h0000, 16'h07A0};
   pmc_word_t pats [4] = '{16'hFFFF, 16'hAAAA, 16'h5555, 16'h0000};
   // Outputs packed at their register positions, so one compare covers a register
   assign o_w[0] = {8'h00, mac_if_enable, rx_fifo_midpoint_level, tx_fifo_midpoint_level,
      1'b0, tx_clock_shift, rx_clock_shift};
   assign o_w[1] = {11'h000, async_fifo_skip, async_fifo_skip_rx_clock_delay,
      low_latency_slow_modes, 2'b00};
   assign o_w[2] = 16'h0000;
   assign o_w[3] = {4'h0, descrambler_timeout_off, descrambler_recovery_ms, force_fast_link_good,
      enhanced_three_level_detect, enhanced_gap_detect, 1'b0, scrambler_off, odd_nibble_detect,
      early_rx_valid};
   pmc_regs #(.VARIANT(PMC_VAR_FIXED)) u_pmc_regs (.*);
   // Strapped variant shares the bus; only its enable is watched
   pmc_regs #(.VARIANT(PMC_VAR_STRAP)) u_pmc_regs_strap (
      .mclk(mclk),
      .rst_b(rst_b),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(),
      .mac_if_enable_strap(mac_if_enable_strap),
      .serial_page_received_in(serial_page_received_in),
      .serial_negotiation_done_in(serial_negotiation_done_in),
      .mac_if_enable(strap_en),
      .rx_fifo_midpoint_level(),
      .tx_fifo_midpoint_level(),
      .tx_clock_shift(),
      .rx_clock_shift(),
      .async_fifo_skip(),
      .async_fifo_skip_rx_clock_delay(),
      .low_latency_slow_modes(),
      .descrambler_timeout_off(),
      .descrambler_recovery_ms(),
      .force_fast_link_good(),
      .enhanced_three_level_detect(),
      .enhanced_gap_detect(),
      .scrambler_off(),
      .odd_nibble_detect(),
      .early_rx_valid()
   );
   initial forever #10 mclk = ~mclk;
   task conclude();
      $display("Checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude
   task chk(input pmc_word_t seen, input pmc_word_t exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // One-cycle strobes; the gap cycle keeps each strobe assigned once per step
   task wr(input pmc_addr_t a, input pmc_word_t d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   task rd(input pmc_addr_t a, output pmc_word_t d);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   // Fixed variant comes up enabled whatever the strap; the other follows the strap
   task t_reset();
      pmc_word_t v;
      for (int i = 0; i < 4; i++) begin
         rd(adr[i], v);
         chk(v, rst_v[i]);
         chk(o_w[i], rst_v[i]);
      end
      chk({15'h0000, strap_en}, {15'h0000, mac_if_enable_strap});
   endtask : t_reset
   task t_pats();
      pmc_word_t v;
      for (int p = 0; p < 4; p++) begin
         for (int i = 0; i < 4; i++) begin
            wr(adr[i], pats[p]);
            chk(o_w[i], pats[p] & msk[i]);
            rd(adr[i], v);
            chk(v, pats[p] & msk[i]);
         end
      end
   endtask : t_pats
   task t_unmapped();
      pmc_word_t v;
      wr(7'h03, 16'hFFFF);
      wr(7'h72, 16'hFFFF);
      wr(7'h34, 16'hFFFF);
      rd(7'h34, v);
      chk(v, 16'h0000);
      for (int i = 0; i < 4; i++) chk(o_w[i], 16'h0000);
   endtask : t_unmapped
   // Fixed wait covers the synchroniser latency
   task t_status();
      pmc_word_t v;
      for (int k = 1; k < 5; k++) begin
         @(posedge mclk);
         serial_page_received_in <= k[1];
         serial_negotiation_done_in <= k[0];
         repeat (6) @(posedge mclk);
         rd(7'h37, v);
         chk(v, {14'h0000, k[1:0]});
      end
   endtask : t_status
   // Strobes back to back: two writes, then two reads, no idle cycle
   task t_b2b();
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= 7'h43;
      reg_wdata <= 16'hF00F;
      @(posedge mclk);
      reg_addr <= 7'h33;
      reg_wdata <= 16'hFFFF;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      reg_addr <= 7'h43;
      @(posedge mclk);
      reg_addr <= 7'h33;
      #1 chk(reg_rdata, 16'hF00F & `PMC_WMSK_FEC);
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, 16'hFFFF & `PMC_WMSK_CTL2);
      @(posedge mclk);
      #1 chk(reg_rdata, 16'h0000);
      chk(o_w[3], 16'hF00F & `PMC_WMSK_FEC);
   endtask : t_b2b
   initial begin
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      t_reset();
      t_pats();
      t_unmapped();
      t_status();
      t_b2b();
      @(posedge mclk);
      rst_b <= 1'b0;
      mac_if_enable_strap <= 1'b1;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      t_reset();
      conclude();
   end
   initial begin
      #1000000;
      errors++;
      conclude();
   end
endmodule : pmc_regs_tb_top
bind pmc_regs pmc_regs_properties u_pmc_regs_properties (.*);
